// >>> dv/adtdm_dma_model.sv
// DMA controller stand-in: counts requests and flags the last transfer.
// Assumes one-cycle requests on the converter clock; every request is served at once.
`timescale 1ns/1ps
module adtdm_dma_model (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Requests and block length in, completion and count out.
  input wire logic dma_req_in,
  input wire logic [7:0] len_in,
  output logic done_out,
  output logic [7:0] count_out
);
  // Completion pulses the cycle after the request that fills the block.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= 8'h00;
      done_out <= 1'b0;
    end else begin
      count_out <= count_out + 8'(dma_req_in);
      done_out <= dma_req_in && (count_out + 8'h01 == len_in);
    end
  end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the trigger and data manager.
// Assumes a zero-wait APB slave and the DMA model on the far side.
`timescale 1ns/1ps
module tb_top import adtdm_pkg::*;;
  ////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals.
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00, dma_len = 8'h00, dma_cnt, c0;
  logic [31:0] pwdata = 32'h0, prdata, rd, ex;
  logic [2:0] trg = 3'h0;
  logic [11:0] raw = 12'h000, m;
  logic pready, pslverr, err, samp, conv, dreq, ddone, irq;
  int miscompares = 0, tests_run = 0, cyc = 0, conv_cyc = 0, smp_cyc = 0;
  always #5 mclk = ~mclk;
  // Cycle ceiling cuts a hang short; conv_cyc measures approximation length.
  always @(posedge mclk) begin
    cyc++;
    if (conv) conv_cyc++;
    if (samp) smp_cyc++;
    if (cyc > 20000) begin
      miscompares++;
      close_out();
    end
  end
  adtdm_core dut (.mclk_in(mclk), .rst_in(rst), .ce_in(1'b1), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .timer_a_trig_out_in(trg[0]), .timer_a_compare4_in(trg[1]),
    .timer_b_trig_out_in(trg[2]), .sar_data_in(raw), .sampling_out(samp),
    .converting_out(conv), .dma_transfer_complete_in(ddone), .dma_req_out(dreq),
    .irq_out(irq));
  adtdm_dma_model dma (.mclk_in(mclk), .rst_in(rst), .dma_req_in(dreq),
    .len_in(dma_len), .done_out(ddone), .count_out(dma_cnt));
  ////////////////////////////////////////////////////////////////////////
  // One APB transfer; an idle cycle follows so psel is never driven twice at once.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge mclk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Polls the busy bit with a bounded count.
  task run(input logic [11:0] v);
    int n;
    n = 0;
    raw <= v;
    conv_cyc = 0;
    smp_cyc = 0;
    apb(1'b1, ADDR_CTRL, 32'h1);
    do begin apb(1'b0, ADDR_CTRL, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 60);
    chk(32'(rd[0]), 32'h0);
  endtask
  // Acts as the DMA data read: waits for a request, then fetches the result.
  task serve;
    int n;
    n = 0;
    do begin @(negedge mclk); n++; end while (dreq !== 1'b1 && n < 100);
    chk(32'(dreq), 32'h1);
    @(posedge mclk);
    apb(1'b0, ADDR_RESULT, 32'h0);
  endtask
  task irq_chk(input logic exp);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge mclk);
  endtask
  task close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence; trigger fields change only while idle.
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdchk(ADDR_FLAG, 32'h0);
    rdchk(ADDR_CTRL, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int r = 0; r < 4; r++) begin
      for (int al = 0; al < 2; al++) begin
        apb(1'b1, ADDR_CFG, 32'((r << 3) | (al << 5)));
        run(12'hABC);
        chk(32'(conv_cyc), 32'(12 - 2 * r));
        chk(32'(smp_cyc), 32'(SMP_CYC));
        rdchk(ADDR_FLAG, 32'h0E);
        chk({31'h0, irq}, 32'h0);
        m = 12'hABC & (12'hFFF << (2 * r));
        ex = al ? {16'h0, m, 4'h0} : 32'(m >> (2 * r));
        rdchk(ADDR_RESULT, ex);
        rdchk(ADDR_FLAG, 32'h0A);
        apb(1'b1, ADDR_FLAG, 32'h1E);
      end
    end
    apb(1'b1, ADDR_IRQEN, 32'h04);
    run(12'h123);
    irq_chk(1'b1);
    apb(1'b0, ADDR_RESULT, 32'h0);
    irq_chk(1'b0);
    apb(1'b1, ADDR_IRQEN, 32'h0);
    apb(1'b1, ADDR_FLAG, 32'h1E);
    // Overrun under both policies; DMA requests are enabled and checked blocked only under the preserve policy.
    apb(1'b1, ADDR_CFG, 32'h3);
    c0 = dma_cnt;
    run(12'h111);
    run(12'h222);
    rdchk(ADDR_FLAG, 32'h1E);
    rdchk(ADDR_RESULT, 32'h111);
    run(12'h333);
    chk(32'(dma_cnt - c0), 32'h1);
    apb(1'b1, ADDR_FLAG, 32'h1E);
    apb(1'b1, ADDR_CFG, 32'h1000);
    run(12'h344);
    run(12'h444);
    rdchk(ADDR_FLAG, 32'h1E);
    rdchk(ADDR_RESULT, 32'h444);
    apb(1'b1, ADDR_FLAG, 32'h1E);
    // One-shot then circular DMA in continuous mode.
    for (int md = 0; md < 2; md++) begin
      apb(1'b1, ADDR_CFG, 32'h2001 | 32'(md << 1));
      c0 = dma_cnt;
      dma_len <= dma_cnt + 8'h03;
      apb(1'b1, ADDR_CTRL, 32'h1);
      repeat (3 + 2 * md) serve();
      repeat (60) @(posedge mclk);
      rdchk(ADDR_CTRL, 32'(md));
      chk(32'(dma_cnt - c0), md ? 32'h6 : 32'h3);
      apb(1'b1, ADDR_CTRL, 32'h2);
      rdchk(ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_FLAG, 32'h1E);
    end
    // Hardware triggers: ignored before start, then the rising, falling and both polarity codes.
    apb(1'b1, ADDR_CFG, 32'hCC0);
    trg[2] <= 1'b1;
    repeat (6) @(posedge mclk);
    trg[2] <= 1'b0;
    repeat (6) @(posedge mclk);
    rdchk(ADDR_FLAG, 32'h0);
    for (int p = 1; p < 4; p++) begin
      apb(1'b1, ADDR_CFG, 32'((p << 10) | ((p == 3 ? 3 : p - 1) << 6)));
      apb(1'b1, ADDR_CTRL, 32'h1);
      repeat (10) @(posedge mclk);
      rdchk(ADDR_FLAG, 32'h0);
      trg[p - 1] <= 1'b1;
      repeat (12) @(posedge mclk);
      rdchk(ADDR_FLAG, 32'((p % 2) * 2));
      trg[p - 1] <= 1'b0;
      repeat (40) @(posedge mclk);
      rdchk(ADDR_FLAG, 32'h0E);
      apb(1'b1, ADDR_CTRL, 32'h2);
      apb(1'b1, ADDR_FLAG, 32'h1E);
    end
    close_out();
  end
endmodule

// >>> rtl/adtdm_core.sv
// Trigger selection, conversion timing, result register, flags and DMA requests.
// Assumes an APB master on mclk_in and a converter core that presents its raw
// 12-bit result on sar_data_in during the last approximation cycle.
//
// Function
// R01: Polarity code selects none, rising, falling, both.
// R02: Triggers ignored while start bit clear.
// R03: Triggers ignored while a conversion runs.
// R04: Source field picks timer event, reserved otherwise.
// R05: Software changes trigger fields only when idle.
// R06: Resolution selects 12, 10, 8 or 6 bits.
// R07: Approximation length follows the selected resolution.
// R08: Conversion flag set on result, cleared two ways.
// R09: Conversion flag with enable raises interrupt.
// R10: Sampling end sets flag, write one clears.
// R11: Last result of sequence sets sequence flag.
// R12: One shared 16-bit result register.
// R13: Alignment bit selects right or left justification.
// R14: Completion with conversion flag set raises overrun.
// R15: Overrun never stops conversions by itself.
// R16: Preserve policy keeps old data during overrun.
// R17: Overwrite policy always stores latest result.
// R18: One DMA request per completed conversion.
// R19: Overrun blocks DMA requests until cleared.
// R20: One-shot mode stops requests after last transfer.
// R21: One-shot end freezes data and aborts sequence.
// R22: Circular mode keeps requesting after last transfer.
// R23: Polling software should prefer the preserve policy.
// R24: Start bit starts now or waits for edge.
// R25: Start bit reads back as busy.
// R26: Trigger synchronised and edge detected once.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module adtdm_core import adtdm_pkg::*; (
  // Clock, reset and enable.
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Timer trigger sources.
  input wire logic timer_a_trig_out_in,
  input wire logic timer_a_compare4_in,
  input wire logic timer_b_trig_out_in,
  // Converter core.
  input wire logic [11:0] sar_data_in,
  output logic sampling_out,
  output logic converting_out,
  // DMA handshake and interrupt.
  input wire logic dma_transfer_complete_in,
  output logic dma_req_out,
  output logic irq_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers and state.
  adtdm_state_t state_ff; // Sequencing state.
  adtdm_state_t nxt_state; // Next sequencing state.
  logic [4:0] cnt_ff; // Phase cycle down-counter.
  logic [4:0] nxt_cnt; // Next counter value.
  logic [3:0] seq_idx_ff; // Position inside the scan sequence.
  logic [31:0] cfg_ff; // Configuration register.
  logic [4:0] flags_ff; // Sticky flags.
  logic [4:0] nxt_flags; // Next flags, set wins over clear.
  logic [4:0] irqen_ff; // Interrupt enables.
  logic [15:0] result_ff; // Shared result register.
  logic dma_stop_ff; // One-shot transfer finished.
  logic dma_req_ff; // One-cycle DMA request.
  logic irq_ff; // Registered interrupt.
  logic [31:0] prdata_ff; // Read data captured in setup.
  logic pslverr_ff; // Error for unmapped address.

  //////////////////////////////////////////////////////////////////////////////
  // Configuration fields.
  wire dma_req_en = cfg_ff[CFG_DMA_REQ_EN];
  wire dma_mode_sel = cfg_ff[CFG_DMAMODE];
  wire [1:0] resolution_field = cfg_ff[CFG_RES_LO +: 2];
  wire align_left = cfg_ff[CFG_ALIGN];
  wire [2:0] trig_source_sel = cfg_ff[CFG_TSEL_LO +: 3];
  wire [1:0] trig_polarity = cfg_ff[CFG_POL_LO +: 2];
  wire overrun_policy = cfg_ff[CFG_OVRPOL];
  wire continuous_sel = cfg_ff[CFG_CONTINUOUS_SEL];
  wire [3:0] seq_last_idx = cfg_ff[CFG_SEQ_LO +: 4];

  //////////////////////////////////////////////////////////////////////////////
  // APB decode. The slave never waits, so every access phase completes.
  wire bus_setup = psel_in & ~penable_in;
  wire bus_wr = psel_in & penable_in & pwrite_in;
  wire bus_rd = psel_in & penable_in & ~pwrite_in;
  wire hit_flag = (paddr_in == ADDR_FLAG);
  wire hit_irqen = (paddr_in == ADDR_IRQEN);
  wire hit_ctrl = (paddr_in == ADDR_CTRL);
  wire hit_cfg = (paddr_in == ADDR_CFG);
  wire hit_result = (paddr_in == ADDR_RESULT);
  wire hit_any = hit_flag | hit_irqen | hit_ctrl | hit_cfg | hit_result;
  wire busy = (state_ff != ST_IDLE);

  // Software commands and flag clears.
  wire start_wr = bus_wr & hit_ctrl & pwdata_in[CTL_START];
  wire conv_stop_cmd = bus_wr & hit_ctrl & pwdata_in[CTL_STOP];
  wire [4:0] flag_w1c = (bus_wr & hit_flag) ? (pwdata_in[4:0] & FLG_MASK) : 5'h00;
  wire result_rd = bus_rd & hit_result;

  // Read multiplexer; the start bit reads back as the busy indicator.
  wire [31:0] rd_mux = hit_flag ? {27'h0000000, flags_ff} :
                       hit_irqen ? {27'h0000000, irqen_ff} :
                       hit_ctrl ? {31'h00000000, busy} : // see R25
                       hit_cfg ? cfg_ff :
                       hit_result ? {16'h0000, result_ff} : 32'h00000000;

  assign pready_out = 1'b1;
  assign prdata_out = prdata_ff;
  assign pslverr_out = pslverr_ff;

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (ce_in && bus_setup) begin
      prdata_ff <= pwrite_in ? 32'h00000000 : rd_mux;
      pslverr_ff <= ~hit_any;
    end
  end

  // Configuration and enable registers take effect at the access edge.
  // Trigger fields are not locked while busy; software must only change them idle.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_ff <= 32'h00000000;
      irqen_ff <= 5'h00;
    end else if (ce_in) begin
      if (bus_wr && hit_cfg) begin
        cfg_ff <= pwdata_in & CFG_WMASK;
      end
      if (bus_wr && hit_irqen) begin
        irqen_ff <= pwdata_in[4:0] & FLG_MASK;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trigger selection and edge detection.
  // Each pin is synchronised before the mux, so a source change cannot fake an edge.
  wire [2:0] trig_pins = {timer_b_trig_out_in, timer_a_compare4_in, timer_a_trig_out_in};
  logic [2:0] src_pulse; // One pulse per qualifying edge of each pin.
  for (genvar gi = 0; gi < $bits(trig_pins); gi++) begin : g_trig
    adtdm_trig_edge u_trig_edge (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .trig_in(trig_pins[gi]),
      .polarity_in(trig_polarity),
      .pulse_out(src_pulse[gi])
    );
  end
  // Only three codes carry an event; reserved codes never trigger.
  wire trig_pulse = (trig_source_sel == SRC_TA_TRGO) ? src_pulse[0] : // see R04
                    (trig_source_sel == SRC_TA_CC4) ? src_pulse[1] :
                    (trig_source_sel == SRC_TB_TRGO) ? src_pulse[2] : 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Conversion timing.
  // Lower resolution shortens the approximation phase.
  wire [4:0] sar_cyc = (resolution_field == RES_12) ? SAR_CYC12 : // see R06 see R07
                       (resolution_field == RES_10) ? SAR_CYC10 :
                       (resolution_field == RES_8) ? SAR_CYC8 : SAR_CYC6;
  wire phase_end = (cnt_ff == CNT_LAST);
  wire dma_end = dma_req_en & ~dma_mode_sel & dma_transfer_complete_in;
  wire abort = conv_stop_cmd | dma_end; // see R21
  wire smp_end = (state_ff == ST_SAMPLE) & phase_end & ~abort;
  wire conv_end = (state_ff == ST_SAR) & phase_end & ~abort;
  wire seq_last = (seq_idx_ff == seq_last_idx);
  wire sw_trig = (trig_polarity == POL_OFF);

  // Next-state logic. Overrun has no say here, so conversions carry on.
  always_comb begin
    nxt_state = state_ff; // see R15
    nxt_cnt = (cnt_ff == 5'h00) ? cnt_ff : cnt_ff - CNT_LAST;
    case (state_ff)
      ST_IDLE: begin
        // Triggers are not looked at here: the start bit is clear.
        if (start_wr) begin // see R02
          if (sw_trig) begin // see R24
            nxt_state = ST_SAMPLE;
            nxt_cnt = SMP_CYC;
          end else begin
            nxt_state = ST_ARMED;
          end
        end
      end
      ST_ARMED: begin
        if (trig_pulse) begin // see R24
          nxt_state = ST_SAMPLE;
          nxt_cnt = SMP_CYC;
        end
      end
      ST_SAMPLE: begin
        // Triggers arriving while converting are dropped.
        if (phase_end) begin // see R03
          nxt_state = ST_SAR;
          nxt_cnt = sar_cyc;
        end
      end
      ST_SAR: begin
        if (phase_end) begin
          nxt_cnt = SMP_CYC;
          if (!seq_last || continuous_sel) begin
            nxt_state = ST_SAMPLE;
          end else if (sw_trig) begin
            nxt_state = ST_IDLE;
          end else begin
            // Hardware-triggered single mode stays armed for the next edge.
            nxt_state = ST_ARMED;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (abort) nxt_state = ST_IDLE; // see R21
  end

  // State, counter and sequence position.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 5'h00;
      seq_idx_ff <= 4'h0;
    end else if (ce_in) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (abort || (conv_end && seq_last)) begin
        seq_idx_ff <= 4'h0;
      end else if (conv_end) begin
        seq_idx_ff <= seq_idx_ff + 4'h1;
      end
    end
  end

  assign sampling_out = (state_ff == ST_SAMPLE);
  assign converting_out = (state_ff == ST_SAR);

  //////////////////////////////////////////////////////////////////////////////
  // Result formatting and storage.
  wire [11:0] res_mask = (resolution_field == RES_12) ? MASK_12 :
                         (resolution_field == RES_10) ? MASK_10 :
                         (resolution_field == RES_8) ? MASK_8 : MASK_6;
  wire [3:0] res_shift = (resolution_field == RES_12) ? SHIFT_12 :
                         (resolution_field == RES_10) ? SHIFT_10 :
                         (resolution_field == RES_8) ? SHIFT_8 : SHIFT_6;
  wire [11:0] raw_kept = sar_data_in & res_mask;
  wire [15:0] right_data = {4'h0, raw_kept} >> res_shift;
  wire [15:0] fmt_data = align_left ? {raw_kept, 4'h0} : right_data; // see R13
  // Preserve policy discards while an overrun is pending or occurring.
  wire ovr_evt = conv_end & flags_ff[FLG_EOC]; // see R14
  wire discard = ~overrun_policy & (flags_ff[FLG_EOC] | flags_ff[FLG_OVR]); // see R16
  wire keep = conv_end & ~dma_stop_ff & ~discard; // see R17 see R21

  // Single result register shared by every channel.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      result_ff <= 16'h0000;
    end else if (ce_in && keep) begin
      result_ff <= fmt_data; // see R12
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt; a hardware set wins over a clear in the same cycle.
  always_comb begin
    nxt_flags = flags_ff & ~flag_w1c; // see R10 see R11 see R14
    // A result read clears the conversion flag; a store in that cycle sets it again.
    if (result_rd) nxt_flags[FLG_EOC] = 1'b0; // see R08
    if (smp_end) nxt_flags[FLG_SMP] = 1'b1; // see R10
    if (keep) nxt_flags[FLG_EOC] = 1'b1; // see R08
    if (conv_end && seq_last) nxt_flags[FLG_SEQ] = 1'b1; // see R11
    if (ovr_evt) nxt_flags[FLG_OVR] = 1'b1; // see R14
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_ff <= 5'h00;
      irq_ff <= 1'b0;
    end else if (ce_in) begin
      flags_ff <= nxt_flags;
      irq_ff <= |(nxt_flags & irqen_ff); // see R09 see R10 see R11 see R14
    end
  end

  assign irq_out = irq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // DMA requests.
  // Requests stop on overrun and, in one-shot mode, after the last transfer.
  wire dma_ok = dma_req_en & ~flags_ff[FLG_OVR] & ~ovr_evt & ~dma_stop_ff; // see R19 see R20
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dma_stop_ff <= 1'b0;
      dma_req_ff <= 1'b0;
    end else if (ce_in) begin
      // Circular mode never sets the stop, so requests continue.
      if (dma_end) begin // see R20 see R22
        dma_stop_ff <= 1'b1;
      end else if (start_wr) begin
        dma_stop_ff <= 1'b0;
      end
      dma_req_ff <= keep & dma_ok & ~dma_end; // see R18
    end
  end

  assign dma_req_out = dma_req_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in || !ce_in);

  logic [4:0] sar_age_ff; // Cycles spent in the approximation phase.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sar_age_ff <= 5'h00;
    end else if (ce_in) begin
      sar_age_ff <= (state_ff == ST_SAR) ? sar_age_ff + 5'h01 : 5'h00;
    end
  end

  sequence s_sw_start;
    (state_ff == ST_IDLE) && start_wr && sw_trig && !abort;
  endsequence

  sw_start_a: assert property (s_sw_start |=> (state_ff == ST_SAMPLE) [*4]) // see R24
    else $error("Software start did not sample for four cycles.");
  idle_ignore_a: assert property ((state_ff == ST_IDLE) && trig_pulse && !start_wr // see R02
    |=> state_ff == ST_IDLE)
    else $error("Trigger acted while the start bit was clear.");
  busy_ignore_a: assert property ((state_ff == ST_SAR) && trig_pulse && !phase_end // see R03
    && !abort |=> state_ff == ST_SAR)
    else $error("Trigger disturbed a running conversion.");
  sar_length_a: assert property (conv_end |-> sar_age_ff == sar_cyc - 5'h01) // see R07
    else $error("Approximation phase length is wrong.");
  eoc_read_a: assert property (result_rd && !keep |=> !flags_ff[FLG_EOC]) // see R08
    else $error("Result read did not clear the conversion flag.");
  eoc_irq_a: assert property (keep && irqen_ff[FLG_EOC] |=> irq_out) // see R09
    else $error("Conversion interrupt missing.");
  ovr_set_a: assert property (conv_end && flags_ff[FLG_EOC] |=> flags_ff[FLG_OVR]) // see R14
    else $error("Overrun flag not set.");
  ovr_keep_a: assert property (conv_end && !overrun_policy && flags_ff[FLG_OVR] // see R16
    |=> $stable(result_ff))
    else $error("Result overwritten under preserve policy.");
  ovr_dma_a: assert property (flags_ff[FLG_OVR] && $past(flags_ff[FLG_OVR]) // see R19
    |-> !dma_req_out)
    else $error("DMA request during overrun.");
  oneshot_end_a: assert property (dma_end |=> (state_ff == ST_IDLE) && !dma_req_out) // see R21
    else $error("One-shot completion did not stop conversion and requests.");
  right_align_a: assert property (keep && !align_left && resolution_field == RES_12 // see R13
    |=> result_ff == {4'h0, $past(sar_data_in)})
    else $error("Right-aligned 12-bit result misplaced.");
endmodule

// >>> rtl/adtdm_pkg.sv
// Constants, field layout and state type for the converter trigger and data manager.
// Assumes a single converter clock that is also the register bus clock.
package adtdm_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] ADDR_FLAG = 8'h00;
  localparam logic [7:0] ADDR_IRQEN = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;

  // Flag and interrupt enable bit positions.
  localparam int FLG_SMP = 1;
  localparam int FLG_EOC = 2;
  localparam int FLG_SEQ = 3;
  localparam int FLG_OVR = 4;
  localparam logic [4:0] FLG_MASK = 5'h1E;

  // Control bit positions.
  localparam int CTL_START = 0;
  localparam int CTL_STOP = 1;

  // Configuration field positions and writable mask.
  localparam int CFG_DMA_REQ_EN = 0;
  localparam int CFG_DMAMODE = 1;
  localparam int CFG_RES_LO = 3;
  localparam int CFG_ALIGN = 5;
  localparam int CFG_TSEL_LO = 6;
  localparam int CFG_POL_LO = 10;
  localparam int CFG_OVRPOL = 12;
  localparam int CFG_CONTINUOUS_SEL = 13;
  localparam int CFG_SEQ_LO = 16;
  localparam logic [31:0] CFG_WMASK = 32'h000F3DFB;

  // Trigger polarity codes.
  localparam logic [1:0] POL_OFF = 2'h0;
  localparam logic [1:0] POL_RISE = 2'h1;
  localparam logic [1:0] POL_FALL = 2'h2;
  localparam logic [1:0] POL_BOTH = 2'h3;

  // Trigger source codes; all others are reserved and select no event.
  localparam logic [2:0] SRC_TA_TRGO = 3'h0;
  localparam logic [2:0] SRC_TA_CC4 = 3'h1;
  localparam logic [2:0] SRC_TB_TRGO = 3'h3;

  // Resolution codes: 12, 10, 8 and 6 bits.
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8 = 2'h2;
  localparam logic [1:0] RES_6 = 2'h3;
  localparam logic [11:0] MASK_12 = 12'hFFF;
  localparam logic [11:0] MASK_10 = 12'hFFC;
  localparam logic [11:0] MASK_8 = 12'hFF0;
  localparam logic [11:0] MASK_6 = 12'hFC0;
  localparam logic [3:0] SHIFT_12 = 4'h0;
  localparam logic [3:0] SHIFT_10 = 4'h2;
  localparam logic [3:0] SHIFT_8 = 4'h4;
  localparam logic [3:0] SHIFT_6 = 4'h6;

  // Phase times in half converter clock cycles, as printed.
  localparam int SMP_HALF = 7;
  localparam int SAR_HALF12 = 25;
  localparam int SAR_HALF10 = 21;
  localparam int SAR_HALF8 = 17;
  localparam int SAR_HALF6 = 13;
  // Sampling rounds up; approximation takes the rest of the whole total.
  localparam logic [4:0] SMP_CYC = 5'((SMP_HALF + 1) / 2);
  localparam logic [4:0] SAR_CYC12 = 5'((SMP_HALF + SAR_HALF12) / 2) - SMP_CYC;
  localparam logic [4:0] SAR_CYC10 = 5'((SMP_HALF + SAR_HALF10) / 2) - SMP_CYC;
  localparam logic [4:0] SAR_CYC8 = 5'((SMP_HALF + SAR_HALF8) / 2) - SMP_CYC;
  localparam logic [4:0] SAR_CYC6 = 5'((SMP_HALF + SAR_HALF6) / 2) - SMP_CYC;
  localparam logic [4:0] CNT_LAST = 5'h01;

  // Converter sequencing states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_SAR = 2'b11
  } adtdm_state_t;

endpackage

// >>> rtl/adtdm_trig_edge.sv
// Trigger synchroniser and polarity-qualified edge detector.
// Assumes the trigger is asynchronous to mclk_in and wider than two clock periods.
`timescale 1ns/1ps
module adtdm_trig_edge import adtdm_pkg::*; (
  // Clock, reset and enable.
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Trigger and polarity.
  input wire logic trig_in,
  input wire logic [1:0] polarity_in,
  // One-cycle start pulse.
  output logic pulse_out
);

  logic meta_ff; // First stage, read only by the second stage.
  logic sync_ff; // Second stage, safe to use.
  logic prev_ff; // Previous synchronised level for edge detection.

  // Two-stage synchroniser followed by one history stage.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else if (ce_in) begin
      meta_ff <= trig_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Each qualifying edge gives exactly one pulse; code zero gives none.
  assign pulse_out = ce_in & ((polarity_in[0] & sync_ff & ~prev_ff) | // see R01 see R26
                              (polarity_in[1] & ~sync_ff & prev_ff));

endmodule
